/* File: verilog/modem_status_consts.svh */
`ifndef MODEM_STATUS_CONSTS_SVH
`define MODEM_STATUS_CONSTS_SVH

// Register offsets on the host register port
`define OFS_DIV_LOW_OR_DATA 3'h0
`define OFS_DIV_HIGH_OR_INT_EN 3'h1
`define OFS_LINE_CONTROL 3'h3
`define OFS_MODEM_CONTROL 3'h4
`define OFS_MODEM_STATUS 3'h6
`define OFS_SCRATCH 3'h7

// Field positions
`define INT_EN_MODEM_IRQ_BIT 3
`define LINE_CTL_DIV_SELECT_BIT 7
`define MODEM_CTL_DTR_BIT 0
`define MODEM_CTL_RTS_BIT 1
`define MODEM_CTL_OUT1_BIT 2
`define MODEM_CTL_OUT2_BIT 3
`define MODEM_CTL_LOOPBACK_BIT 4

// Reset values
`define RST_BYTE 8'h00
`define RST_DIVISOR 16'h0000
`define RST_FLAGS 4'h0

`endif

/* File: verilog/modem_status_pkg.sv */
package modem_status_pkg;

  // Modem status byte: current levels high, change flags low
  typedef struct packed {
    logic [3:0] level; // Carrier, ring, data-set-ready, clear-to-send
    logic [3:0] delta; // Change flags in the same order
  } modem_status_t;

  // One host register request
  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } host_req_t;

endpackage : modem_status_pkg

/* File: verilog/modem_line_watch.sv */
`timescale 1ns/1ns
// Watches one active-low modem input and reports its level and changes
module modem_line_watch #(
  parameter bit FALL_ONLY = 1'b0 // Report only falls of the status level
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Line sources
  input wire logic pin_n,
  input wire logic loop_level,
  input wire logic loopback,
  // Results
  output logic level,
  output logic change
);

  logic sync_a; // First synchroniser stage, read only by sync_b
  logic sync_b; // Second synchroniser stage
  wire logic src_level; // Level the status bit should follow

  // Loopback takes the control bit, otherwise the inverted pin
  assign src_level = loopback ? loop_level : ~sync_b;
  // Any toggle, or only the status fall (pin rising) when asked
  assign change = FALL_ONLY ? (level & ~src_level) : (level ^ src_level);

  // Synchronise the pin and track the status level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      level <= 1'b0;
    end else if (ce) begin
      sync_a <= pin_n;
      sync_b <= sync_a;
      level <= src_level;
    end
  end

endmodule : modem_line_watch

/* File: verilog/modem_status_regs.sv */
`timescale 1ns/1ns
`include "modem_status_consts.svh"
// What this block does
// - Set DSR change flag on any toggle
// - Set ring flag only on ring trailing edge (pin rising)
// - Set carrier change flag on any toggle
// - Interrupt when flag set and enabled
// - Bit4 is inverted CTS, loopback RTS
// - Bit5 is inverted DSR, loopback DTR
// - Bit6 is inverted ring, loopback control bit2
// - Bit7 is inverted carrier, loopback control bit3
// - Change flags are zero after reset
// - Free eight bit scratch register
// - Divisor is high byte over low byte
// - Set CTS change flag on any toggle
// - Loopback follows control bit4, off at reset
// - Divisor bytes selected only by line-control bit7
module modem_status_regs
  import modem_status_pkg::*;
(
  // Clock, reset and enable
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // Host register port
  input wire logic [2:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  // Modem inputs, active low
  input wire logic CTS_N_I,
  input wire logic DSR_N_I,
  input wire logic RING_INDICATOR_N_I,
  input wire logic CARRIER_DETECT_N_I,
  // Results for the rest of the channel
  output logic [15:0] BAUD_DIVISOR_O,
  output logic LOOPBACK_O,
  output logic MODEM_IRQ_O
);

  host_req_t req; // Bundled host request
  logic [7:0] baud_divisor_low; // Divisor low byte
  logic [7:0] baud_divisor_high; // Divisor high byte
  logic [7:0] interrupt_enable_reg; // Interrupt enables
  logic [7:0] line_control_reg; // Line control, only the divisor select used here
  logic [7:0] modem_control_reg; // Modem control
  logic [7:0] scratch_pad; // Scratch storage
  logic [3:0] delta; // Sticky change flags
  wire logic [3:0] level; // Current status levels
  wire logic [3:0] change; // Change pulses from the watchers
  wire logic [3:0] pin_n; // Pins in status bit order
  wire logic [3:0] loop_src; // Control bits that replace pins in loopback
  wire logic loopback; // Loopback active
  wire logic div_sel; // Divisor bytes mapped over the data and interrupt-enable registers
  wire logic status_read; // Host reads the modem status register
  wire logic [3:0] next_delta; // Next change flags
  wire logic next_irq; // Next interrupt level
  wire modem_status_t status; // Assembled status byte
  logic [7:0] read_mux; // Selected read data

  assign req = '{addr: ADDR_I, wr: WR_I, rd: RD_I, wdata: WDATA_I};

  // Decode of control fields
  assign loopback = modem_control_reg[`MODEM_CTL_LOOPBACK_BIT];
  assign div_sel = line_control_reg[`LINE_CTL_DIV_SELECT_BIT];
  assign status_read = req.rd && (req.addr == `OFS_MODEM_STATUS);

  // Pin and loopback sources, ordered CTS, DSR, ring, carrier
  assign pin_n = {CARRIER_DETECT_N_I, RING_INDICATOR_N_I, DSR_N_I, CTS_N_I};
  assign loop_src = {modem_control_reg[`MODEM_CTL_OUT2_BIT],
                     modem_control_reg[`MODEM_CTL_OUT1_BIT],
                     modem_control_reg[`MODEM_CTL_DTR_BIT],
                     modem_control_reg[`MODEM_CTL_RTS_BIT]};

  // One watcher per modem line; the ring watcher reports only its trailing edge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_line
      modem_line_watch #(
        .FALL_ONLY(gi == 2)
      ) u_watch (
        .clk(MCLK_I),
        .rst(SYS_RST_I),
        .ce(CE_I),
        .pin_n(pin_n[gi]),
        .loop_level(loop_src[gi]),
        .loopback(loopback),
        .level(level[gi]),
        .change(change[gi])
      );
    end
  endgenerate

  // Flags: a change in the read cycle survives the clear
  assign next_delta = (status_read ? `RST_FLAGS : delta) | change;
  // Interrupt follows the flags that remain after this cycle
  assign next_irq = (|next_delta) & interrupt_enable_reg[`INT_EN_MODEM_IRQ_BIT];

  // Status byte: levels high, change flags low
  assign status = '{level: level, delta: delta};

  // Read selection; unmapped and outside registers read zero
  always_comb begin
    read_mux = 8'h00;
    unique case (req.addr)
      `OFS_DIV_LOW_OR_DATA: begin
        read_mux = div_sel ? baud_divisor_low : 8'h00;
      end
      `OFS_DIV_HIGH_OR_INT_EN: begin
        read_mux = div_sel ? baud_divisor_high : interrupt_enable_reg;
      end
      `OFS_LINE_CONTROL: begin
        read_mux = line_control_reg;
      end
      `OFS_MODEM_CONTROL: begin
        read_mux = modem_control_reg;
      end
      `OFS_MODEM_STATUS: begin
        read_mux = status;
      end
      `OFS_SCRATCH: begin
        read_mux = scratch_pad;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // Host writes to the control, divisor and scratch registers
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      baud_divisor_low <= `RST_BYTE;
      baud_divisor_high <= `RST_BYTE;
      interrupt_enable_reg <= `RST_BYTE;
      line_control_reg <= `RST_BYTE;
      modem_control_reg <= `RST_BYTE;
      scratch_pad <= `RST_BYTE;
    end else if (CE_I && req.wr) begin
      unique case (req.addr)
        `OFS_DIV_LOW_OR_DATA: begin
          if (div_sel) begin
            baud_divisor_low <= req.wdata;
          end
        end
        `OFS_DIV_HIGH_OR_INT_EN: begin
          if (div_sel) begin
            baud_divisor_high <= req.wdata;
          end else begin
            interrupt_enable_reg <= req.wdata;
          end
        end
        `OFS_LINE_CONTROL: begin
          line_control_reg <= req.wdata;
        end
        `OFS_MODEM_CONTROL: begin
          modem_control_reg <= req.wdata;
        end
        `OFS_SCRATCH: begin
          scratch_pad <= req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Change flags, interrupt and read data
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      delta <= `RST_FLAGS;
      MODEM_IRQ_O <= 1'b0;
      RDATA_O <= `RST_BYTE;
    end else if (CE_I) begin
      delta <= next_delta;
      MODEM_IRQ_O <= next_irq;
      if (req.rd) begin
        RDATA_O <= read_mux;
      end
    end
  end

  // Registered copies of the divisor and loopback for the rest of the channel
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      BAUD_DIVISOR_O <= `RST_DIVISOR;
      LOOPBACK_O <= 1'b0;
    end else if (CE_I) begin
      BAUD_DIVISOR_O <= {baud_divisor_high, baud_divisor_low};
      LOOPBACK_O <= loopback;
    end
  end

endmodule : modem_status_regs

/* File: sim/modem_status_sva.sv */
`timescale 1ns/1ns
// Port-level checks of the modem status block
module modem_status_sva (
  // Clock, reset and host port
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic [2:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] RDATA_O,
  // Modem pins
  input wire logic CTS_N_I,
  input wire logic DSR_N_I,
  input wire logic RING_INDICATOR_N_I,
  input wire logic CARRIER_DETECT_N_I,
  // Results
  input wire logic [15:0] BAUD_DIVISOR_O,
  input wire logic LOOPBACK_O,
  input wire logic MODEM_IRQ_O
);
  wire logic [3:0] pins = {CARRIER_DETECT_N_I, RING_INDICATOR_N_I, DSR_N_I, CTS_N_I};
  wire logic wr = CE_I && WR_I; // Write taken
  wire logic rdst = CE_I && RD_I && !WR_I && ADDR_I == 3'h6; // Status read taken
  logic [7:0] line_ctl, modem_ctl, scratch, dl, dm; // Copies of written registers
  // Mirror host writes
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      {line_ctl, modem_ctl, scratch, dl, dm} <= '0;
    end else if (wr) begin
      if (ADDR_I == 3'h3) line_ctl <= WDATA_I;
      if (ADDR_I == 3'h4) modem_ctl <= WDATA_I;
      if (ADDR_I == 3'h7) scratch <= WDATA_I;
      if (ADDR_I == 3'h0 && line_ctl[7]) dl <= WDATA_I;
      if (ADDR_I == 3'h1 && line_ctl[7]) dm <= WDATA_I;
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Pins and registers left alone long enough to settle
  sequence quiet_s;
    (CE_I && !WR_I && $stable(pins))[*4];
  endsequence
  rst_clear_a: assert property ($fell(SYS_RST_I) |-> !MODEM_IRQ_O && !LOOPBACK_O)
    else $error("outputs not clear after reset");
  lb_follow_a: assert property (wr && ADDR_I == 3'h4 ##1 CE_I |=>
    LOOPBACK_O == $past(WDATA_I[4], 2)) else $error("loopback output wrong");
  irq_drop_a: assert property (quiet_s ##0 rdst |=> !MODEM_IRQ_O)
    else $error("interrupt kept after status read");
  lvl_pin_a: assert property (quiet_s ##0 (rdst && !LOOPBACK_O) |=>
    RDATA_O[7:4] == ~$past(pins)) else $error("status levels not inverted pins");
  lvl_loop_a: assert property (quiet_s ##0 (rdst && LOOPBACK_O) |=>
    RDATA_O[7:4] == {modem_ctl[3], modem_ctl[2], modem_ctl[0], modem_ctl[1]})
    else $error("loopback levels wrong");
  flag_clear_a: assert property (quiet_s ##0 rdst ##1 (CE_I && !RD_I && !WR_I) ##1
    (rdst && $stable(pins)) |=> RDATA_O[3:0] == 4'h0) else $error("flags not cleared");
  spr_back_a: assert property (CE_I && RD_I && !WR_I && ADDR_I == 3'h7 |=>
    RDATA_O == $past(scratch)) else $error("scratch readback wrong");
  div_form_a: assert property ((CE_I && !WR_I)[*2] |->
    BAUD_DIVISOR_O == {dm, dl}) else $error("divisor wrong");
endmodule : modem_status_sva

/* File: sim/modem_partner.sv */
`timescale 1ns/1ns
// Modem side: drives the active-low status lines, idle high
module modem_partner (
  // Clock
  input wire logic clk_i,
  // Requested levels and pins: carrier, ring, data-set-ready, clear-to-send
  input wire logic [3:0] want_n_i,
  output logic [3:0] pins_n_o = 4'hf
);
  // Lines move just after an edge, unrelated to host cycles
  always @(posedge clk_i) begin
    pins_n_o <= want_n_i;
  end
endmodule : modem_partner

/* File: sim/modem_status_regs_tb_top.sv */
`timescale 1ns/1ns
// Host and modem stimulus for the modem status block
module modem_status_regs_tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b0, wr = 1'b0, rd = 1'b0; // Host drives
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] want_n = 4'hf; // Lines asked of the modem
  wire logic [3:0] pins_n;
  wire logic [7:0] rdata;
  wire logic [15:0] div;
  wire logic loopback, irq;
  int error_cnt = 0, checks_done = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  modem_partner i_modem (.clk_i(clk), .want_n_i(want_n), .pins_n_o(pins_n));
  modem_status_regs i_dut (.MCLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .CTS_N_I(pins_n[0]),
    .DSR_N_I(pins_n[1]), .RING_INDICATOR_N_I(pins_n[2]), .CARRIER_DETECT_N_I(pins_n[3]),
    .BAUD_DIVISOR_O(div), .LOOPBACK_O(loopback), .MODEM_IRQ_O(irq));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  // One-cycle read strobe, data compared once settled
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(16'(rdata), 16'(exp));
  endtask : rd_chk
  // Move the modem lines, then check interrupt, status and clearing
  task automatic pulse(input logic [3:0] p, input logic [7:0] exp, input logic ie);
    want_n <= p;
    repeat (6) @(posedge clk);
    chk(16'(irq), 16'(ie && exp[3:0] != 4'h0));
    rd_chk(3'h6, exp);
    chk(16'(irq), 16'h0);
  endtask : pulse
  // Verdict
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    rd_chk(3'h6, 8'h00);
    wr_reg(3'h7, 8'ha5);
    rd_chk(3'h7, 8'ha5);
    rd_chk(3'h2, 8'h00);
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h0, 8'h34);
    wr_reg(3'h1, 8'h12);
    rd_chk(3'h1, 8'h12);
    chk(div, 16'h1234);
    wr_reg(3'h3, 8'h00);
    wr_reg(3'h0, 8'hff);
    rd_chk(3'h0, 8'h00);
    chk(div, 16'h1234);
    wr_reg(3'h1, 8'h08);
    for (int i = 0; i < 4; i++) begin
      pulse(4'hf ^ (4'h1 << i), {4'h1 << i, (i == 2) ? 4'h0 : 4'h1 << i}, 1'b1);
      pulse(4'hf, {4'h0, 4'h1 << i}, 1'b1);
    end
    wr_reg(3'h1, 8'h00);
    pulse(4'he, 8'h11, 1'b0);
    wr_reg(3'h4, 8'h1f);
    want_n <= 4'h0;
    repeat (6) @(posedge clk);
    chk(16'(loopback), 16'h1);
    rd_chk(3'h6, 8'hfa);
    rd_chk(3'h6, 8'hf0);
    wr_reg(3'h4, 8'h12);
    pulse(4'h0, 8'h1e, 1'b0);
    wr_reg(3'h4, 8'h00);
    pulse(4'h0, 8'hfa, 1'b0);
    tally_and_finish();
  end
endmodule : modem_status_regs_tb_top
bind modem_status_regs modem_status_sva i_sva (.MCLK_I, .SYS_RST_I, .CE_I, .ADDR_I, .WR_I,
  .RD_I, .WDATA_I, .RDATA_O, .CTS_N_I, .DSR_N_I, .RING_INDICATOR_N_I, .CARRIER_DETECT_N_I,
  .BAUD_DIVISOR_O, .LOOPBACK_O, .MODEM_IRQ_O);
